// File: pkg/sacq_pkg.sv
// Package of register map, field layout and timing constants for the acquisition sequencer
package sacq_pkg;
  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned MUX_SETTLE_NS = 80;
  localparam int unsigned MUX_SETTLE_CYC = (MUX_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_CONFIG   = 8'h04;
  localparam logic [7:0] REG_INTERVAL = 8'h08;
  localparam logic [7:0] REG_COUNT    = 8'h0c;
  localparam logic [7:0] REG_STATUS   = 8'h10;
  localparam logic [7:0] REG_ACQCNT   = 8'h14;
  localparam logic [7:0] REG_RDPTR    = 8'h18;
  localparam logic [7:0] REG_DATA     = 8'h1c;
  // ==========================================================================
  // Field positions
  localparam int CTRL_LAUNCH    = 0;
  localparam int CTRL_ABORT     = 1;
  localparam int CFG_EXT_CONV   = 0;
  localparam int CFG_EXT_GATE   = 1;
  localparam int CFG_MODE_LSB   = 2;
  localparam int CFG_TB_LSB     = 4;
  localparam int CFG_TB_ROUTE   = 8;
  localparam int CFG_CHAN_LSB   = 16;
  localparam int CFG_GAIN_LSB   = 24;
  localparam int STAT_DONE      = 0;
  localparam int STAT_ACTIVE    = 1;
  localparam int CHAN_W         = 6;
  localparam int GAIN_W         = 3;
  localparam int TB_W           = 4;
  localparam int INTERVAL_W     = 25;
  localparam int COUNT_W        = 31;
  localparam int SAMPLE_W       = 16;
  // ==========================================================================
  // Reset values and limits
  localparam logic [31:0] CONFIG_RST   = 32'h0000_0010;
  localparam logic [24:0] INTERVAL_RST = 25'h000_0002;
  localparam logic [24:0] INTERVAL_MIN = 25'h000_0002;
  localparam logic [30:0] COUNT_RST    = 31'h0000_0003;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  // ==========================================================================
  // Timebase codes and buffer modes
  localparam logic [3:0] TB_EXTERNAL = 4'h0;
  localparam logic [3:0] TB_1MHZ     = 4'h1;
  localparam logic [3:0] TB_100KHZ   = 4'h2;
  localparam logic [3:0] TB_10KHZ    = 4'h3;
  localparam logic [3:0] TB_1KHZ     = 4'h4;
  localparam logic [3:0] TB_100HZ    = 4'h5;
  localparam logic [3:0] TB_20MHZ    = 4'hd;
  typedef enum logic [1:0] {
    SACQ_SINGLE = 2'h0,
    SACQ_DOUBLE = 2'h1,
    SACQ_CONT   = 2'h2
  } sacq_mode_t;
  typedef enum logic [2:0] {
    SACQ_IDLE   = 3'b001,
    SACQ_SETTLE = 3'b010,
    SACQ_RUN    = 3'b100
  } sacq_state_t;
endpackage

// File: verilog/sacq_interval_timer.sv
// Timebase prescaler and reloading sample-interval counter
module sacq_interval_timer #(
  parameter bit EXTENDED = 1'b1
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic                        load,
  input  wire logic                        run,
  input  wire logic [sacq_pkg::TB_W-1:0]   tb_code,
  input  wire logic                        ext_tick,
  input  wire logic [sacq_pkg::INTERVAL_W-1:0] interval,
  output logic                             conv_ff
);
  logic [31:0]                         acc_ff;
  logic [sacq_pkg::INTERVAL_W-1:0]     cnt_ff;
  logic [31:0]                         rate;
  logic                                tick;

  // ==========================================================================
  // Timebase rate per code
  function automatic logic [31:0] tb_rate(input logic [3:0] code);
    case (code)
      sacq_pkg::TB_1MHZ:   tb_rate = 32'd1_000_000;
      sacq_pkg::TB_100KHZ: tb_rate = 32'd100_000;
      sacq_pkg::TB_10KHZ:  tb_rate = 32'd10_000;
      sacq_pkg::TB_1KHZ:   tb_rate = 32'd1_000;
      sacq_pkg::TB_100HZ:  tb_rate = 32'd100;
      sacq_pkg::TB_20MHZ:  tb_rate = EXTENDED ? 32'd20_000_000 : 32'd0;
      default:             tb_rate = 32'd0;
    endcase
  endfunction

  assign rate = tb_rate(tb_code);
  assign tick = (tb_code == sacq_pkg::TB_EXTERNAL) ? ext_tick : (acc_ff + rate >= sacq_pkg::CLK_HZ);

  // Fractional accumulator gives exact average tick rate
  always_ff @(posedge aclk) begin
    if (!aresetn || load) begin
      acc_ff <= 32'h0000_0000;
    end else if (tb_code != sacq_pkg::TB_EXTERNAL) begin
      acc_ff <= tick ? acc_ff + rate - sacq_pkg::CLK_HZ : acc_ff + rate;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || load) begin
      cnt_ff  <= interval;
      conv_ff <= 1'b0;
    end else begin
      conv_ff <= 1'b0;
      if (run && tick) begin
        if (cnt_ff <= 25'h000_0001) begin
          cnt_ff  <= interval;
          conv_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff - 25'h000_0001;
        end
      end
    end
  end

  sequence terminal_tick_s;
    run && tick && cnt_ff <= 25'h000_0001 && !load;
  endsequence

  interval_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
    terminal_tick_s |=> conv_ff && cnt_ff == $past(interval))
    else $error("no strobe or reload at terminal count");

  gate_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !run |=> !conv_ff)
    else $error("conversion while counter suspended");
endmodule // sacq_interval_timer

// File: verilog/sacq_top.sv
// Single-channel acquisition sequencer with AXI4-Lite register slave and sample memory
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
module sacq_top #(
  parameter bit EXTENDED = 1'b1,
  parameter int DEPTH    = 256
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        convert_pulse_in_n,
  input  wire logic        acq_gate_in,
  input  wire logic        ext_timebase_in,
  input  wire logic        default_prog_input_pin,
  input  wire logic [15:0] adc_result,
  input  wire logic        adc_result_valid,
  output logic [5:0]       adc_chan,
  output logic [2:0]       adc_gain,
  output logic             adc_start
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [3:0]               sync1_ff, sync2_ff, sync3_ff;
  logic                     awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic                     aw_held_ff, w_held_ff;
  logic [7:0]               awaddr_ff;
  logic [31:0]              wdata_ff, rdata_ff, config_ff;
  logic [3:0]               wstrb_ff;
  logic [1:0]               bresp_ff, rresp_ff;
  logic [24:0]              interval_ff;
  logic [30:0]              count_ff, acq_cnt_ff;
  logic [AW-1:0]            wptr_ff, rdptr_ff;
  logic [15:0]              mem [DEPTH];
  logic [5:0]               chan_ff;
  logic [2:0]               gain_ff;
  logic                     start_ff, done_ff, armed_ff;
  logic [7:0]               settle_ff;
  sacq_pkg::sacq_state_t    state_ff;
  logic                     wr_fire, rd_fire, launch, abort, conv_req, tmr_conv, last_sample;
  logic                     ext_conv, ext_gate, conv_fall, conv_rise, tb_rise, pin_rise, tmr_run;
  sacq_pkg::sacq_mode_t     mode;
  logic [31:0]              interval_wr, count_wr;

  // ==========================================================================
  // Address decode shared by both channels
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'h0) && (a <= sacq_pkg::REG_DATA);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // ==========================================================================
  // Pin synchronisers, two flops each, third flop for edges
  logic [3:0] pins;
  assign pins = {default_prog_input_pin, ext_timebase_in, acq_gate_in, convert_pulse_in_n};
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sync1_ff[g] <= 1'b0;
          sync2_ff[g] <= 1'b0;
          sync3_ff[g] <= 1'b0;
        end else begin
          sync1_ff[g] <= pins[g];
          sync2_ff[g] <= sync1_ff[g];
          sync3_ff[g] <= sync2_ff[g];
        end
      end
    end
  endgenerate
  assign conv_fall = !sync2_ff[0] && sync3_ff[0];
  assign conv_rise = sync2_ff[0] && !sync3_ff[0];
  assign tb_rise   = sync2_ff[2] && !sync3_ff[2];
  assign pin_rise  = sync2_ff[3] && !sync3_ff[3];

  // ==========================================================================
  // AXI4-Lite write channel
  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= sacq_pkg::RESP_OKAY;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        awaddr_ff  <= s_axi_awaddr;
        aw_held_ff <= 1'b1;
        awready_ff <= 1'b0;
      end
      if (s_axi_wvalid && wready_ff) begin
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
        w_held_ff <= 1'b1;
        wready_ff <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= addr_ok(awaddr_ff) ? sacq_pkg::RESP_OKAY : sacq_pkg::RESP_SLVERR;
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff  <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff  <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Configuration registers
  // Merged write words for the wide numeric registers
  assign interval_wr = merge({7'h00, interval_ff}, wdata_ff, wstrb_ff);
  assign count_wr    = merge({1'b0, count_ff}, wdata_ff, wstrb_ff);

  // reset to software start, internal timing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_ff   <= sacq_pkg::CONFIG_RST;
      interval_ff <= sacq_pkg::INTERVAL_RST;
      count_ff    <= sacq_pkg::COUNT_RST;
    end else if (wr_fire) begin
      case (awaddr_ff)
        sacq_pkg::REG_CONFIG:   config_ff <= merge(config_ff, wdata_ff, wstrb_ff);
        sacq_pkg::REG_INTERVAL: interval_ff <= (interval_wr < 32'h0000_0002) ?
                                  sacq_pkg::INTERVAL_MIN : interval_wr[24:0];
        // count held as 31 bits, host keeps range
        sacq_pkg::REG_COUNT:    count_ff <= count_wr[30:0];
        default:                config_ff <= config_ff;
      endcase
    end
  end
  assign ext_conv = config_ff[sacq_pkg::CFG_EXT_CONV];
  assign ext_gate = config_ff[sacq_pkg::CFG_EXT_GATE];
  assign mode     = sacq_pkg::sacq_mode_t'(config_ff[sacq_pkg::CFG_MODE_LSB +: 2]);
  assign launch   = wr_fire && awaddr_ff == sacq_pkg::REG_CTRL && wstrb_ff[0] && wdata_ff[sacq_pkg::CTRL_LAUNCH];
  assign abort    = wr_fire && awaddr_ff == sacq_pkg::REG_CTRL && wstrb_ff[0] && wdata_ff[sacq_pkg::CTRL_ABORT];

  // ==========================================================================
  // AXI4-Lite read channel, data port pops the read pointer
  assign rd_fire = s_axi_arvalid && arready_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= sacq_pkg::RESP_OKAY;
    end else begin
      if (rd_fire) begin
        arready_ff <= 1'b0;
        rvalid_ff  <= 1'b1;
        rresp_ff   <= addr_ok(s_axi_araddr) ? sacq_pkg::RESP_OKAY : sacq_pkg::RESP_SLVERR;
        case (s_axi_araddr)
          sacq_pkg::REG_CONFIG:   rdata_ff <= config_ff;
          sacq_pkg::REG_INTERVAL: rdata_ff <= {7'h00, interval_ff};
          sacq_pkg::REG_COUNT:    rdata_ff <= {1'b0, count_ff};
          sacq_pkg::REG_STATUS:   rdata_ff <= {30'h0, state_ff != sacq_pkg::SACQ_IDLE, done_ff};
          sacq_pkg::REG_ACQCNT:   rdata_ff <= {1'b0, acq_cnt_ff};
          sacq_pkg::REG_RDPTR:    rdata_ff <= 32'(rdptr_ff);
          sacq_pkg::REG_DATA:     rdata_ff <= {16'h0000, mem[rdptr_ff]};
          default:                rdata_ff <= 32'h0000_0000;
        endcase
      end
      if (rvalid_ff && s_axi_rready) begin
        rvalid_ff  <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  // Read pointer: written directly, advanced by each data read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdptr_ff <= '0;
    end else if (wr_fire && awaddr_ff == sacq_pkg::REG_RDPTR) begin
      rdptr_ff <= wdata_ff[AW-1:0];
    end else if (rd_fire && s_axi_araddr == sacq_pkg::REG_DATA) begin
      rdptr_ff <= (rdptr_ff == LAST) ? '0 : rdptr_ff + 1'b1;
    end
  end

  // ==========================================================================
  // Interval timer and conversion request
  // gate level enables counter
  assign tmr_run = state_ff == sacq_pkg::SACQ_RUN && !ext_conv && (!ext_gate || sync2_ff[1]);
  sacq_interval_timer #(
    .EXTENDED (EXTENDED)
  ) u_timer (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .load     (state_ff != sacq_pkg::SACQ_RUN),
    .run      (tmr_run),
    .tb_code  (config_ff[sacq_pkg::CFG_TB_LSB +: 4]),
    .ext_tick ((EXTENDED && !config_ff[sacq_pkg::CFG_TB_ROUTE]) ? pin_rise : tb_rise),
    .interval (interval_ff),
    .conv_ff  (tmr_conv)
  );
  assign conv_req    = state_ff == sacq_pkg::SACQ_RUN && (ext_conv ? (armed_ff && conv_fall) : tmr_conv);
  assign last_sample = mode != sacq_pkg::SACQ_CONT && acq_cnt_ff + 31'h1 >= count_ff;

  // ==========================================================================
  // Sequencer state, mux setup, storage and completion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff   <= sacq_pkg::SACQ_IDLE;
      chan_ff    <= '0;
      gain_ff    <= '0;
      settle_ff  <= 8'h00;
      done_ff    <= 1'b0;
      armed_ff   <= 1'b0;
      start_ff   <= 1'b0;
      acq_cnt_ff <= '0;
      wptr_ff    <= '0;
    end else begin
      start_ff <= conv_req;
      case (state_ff)
        sacq_pkg::SACQ_IDLE: begin
          if (launch) begin
            chan_ff    <= config_ff[sacq_pkg::CFG_CHAN_LSB +: 6];
            gain_ff    <= config_ff[sacq_pkg::CFG_GAIN_LSB +: 3];
            settle_ff  <= 8'(sacq_pkg::MUX_SETTLE_CYC);
            done_ff    <= 1'b0;
            acq_cnt_ff <= '0;
            wptr_ff    <= '0;
            state_ff   <= sacq_pkg::SACQ_SETTLE;
          end
        end
        sacq_pkg::SACQ_SETTLE: begin
          armed_ff  <= 1'b0;
          settle_ff <= settle_ff - 8'h01;
          if (abort) begin
            state_ff <= sacq_pkg::SACQ_IDLE;
          end else if (settle_ff <= 8'h01) begin
            state_ff <= sacq_pkg::SACQ_RUN;
          end
        end
        sacq_pkg::SACQ_RUN: begin
          if (conv_rise) begin
            armed_ff <= 1'b1;
          end
          if (abort) begin
            state_ff <= sacq_pkg::SACQ_IDLE;
          end else if (adc_result_valid) begin
            acq_cnt_ff <= (acq_cnt_ff == 31'h7fff_ffff) ? acq_cnt_ff : acq_cnt_ff + 31'h1;
            wptr_ff    <= (wptr_ff == LAST) ? ((mode == sacq_pkg::SACQ_SINGLE) ? LAST : '0) : wptr_ff + 1'b1;
            if (last_sample) begin
              done_ff  <= 1'b1;
              state_ff <= sacq_pkg::SACQ_IDLE;
            end
          end
        end
        default: state_ff <= sacq_pkg::SACQ_IDLE;
      endcase
    end
  end

  // one 16-bit word per conversion, in order
  // nothing stored once single buffer complete or full
  always_ff @(posedge aclk) begin
    if (state_ff == sacq_pkg::SACQ_RUN && adc_result_valid && !abort &&
        !(mode == sacq_pkg::SACQ_SINGLE && acq_cnt_ff >= 31'(DEPTH))) begin
      mem[wptr_ff] <= adc_result;
    end
  end

  // ==========================================================================
  // Outputs
  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign adc_chan      = chan_ff;
  assign adc_gain      = gain_ff;
  assign adc_start     = start_ff;

  // ==========================================================================
  // Checks
  launch_mux_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_ff == sacq_pkg::SACQ_IDLE && launch |=> adc_chan == $past(config_ff[21:16]) && !adc_start)
    else $error("channel not set at launch");
  settle_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_ff == sacq_pkg::SACQ_SETTLE |=> !adc_start)
    else $error("conversion before mux settled");
  single_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_ff == sacq_pkg::SACQ_RUN && adc_result_valid && !abort && last_sample
    |=> done_ff && state_ff == sacq_pkg::SACQ_IDLE)
    else $error("completion did not end acquisition");
  ext_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_ff == sacq_pkg::SACQ_RUN && ext_conv && armed_ff && conv_fall |=> adc_start ##1 !adc_start)
    else $error("external pulse did not give one conversion");
  first_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_ff == sacq_pkg::SACQ_RUN && ext_conv && !armed_ff |=> !adc_start)
    else $error("conversion before rising edge seen");
  busy_launch_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_ff == sacq_pkg::SACQ_RUN && launch && !abort |=> $stable(adc_chan) && !done_ff [*1])
    else $error("launch accepted while active");
  cont_run_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_ff == sacq_pkg::SACQ_RUN && mode == sacq_pkg::SACQ_CONT && !abort |=> state_ff == sacq_pkg::SACQ_RUN)
    else $error("continuous run stopped without abort");
  reset_cfg_a: assert property (@(posedge aclk)
    !aresetn |=> !ext_conv && !ext_gate)
    else $error("reset configuration wrong");
endmodule // sacq_top

// File: testbench/sacq_adc_model.sv
// Converter model answering each start request with one result
module sacq_adc_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        adc_start,
  output logic [15:0]      adc_result,
  output logic             adc_result_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] seq_ff;
  logic [1:0]  dly_ff;
  // ==========================================================================
  // Conversion latency
  // one 16-bit result per start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_ff           <= 16'h5a00;
      dly_ff           <= 2'h0;
      adc_result_valid <= 1'b0;
      adc_result       <= 16'hffff;
    end else begin
      dly_ff           <= {dly_ff[0], adc_start};
      adc_result_valid <= dly_ff[1];
      adc_result       <= dly_ff[1] ? seq_ff : ~adc_result; // Not valid: toggling junk
      if (dly_ff[1]) begin
        seq_ff <= seq_ff + 16'h0001;
      end
    end
  end
endmodule // sacq_adc_model

// File: testbench/tb_top.sv
// Self-checking bench for the acquisition sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic conv_n = 1, gate = 0, awready, wready, bvalid, arready, rvalid, adc_start, res_v;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic [15:0] res;
  logic [5:0]  chan_o, chan;
  logic [2:0]  gain_o, gain;
  int          n_errors = 0, comparisons = 0, nst = 0, gap = 0, k;
  time         t0 = 0;
  logic [15:0] q[$];
  sacq_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .convert_pulse_in_n(conv_n),
    .acq_gate_in(gate), .ext_timebase_in(1'b0), .default_prog_input_pin(1'b0), .adc_result(res),
    .adc_result_valid(res_v), .adc_chan(chan_o), .adc_gain(gain_o), .adc_start(adc_start));
  sacq_adc_model i_adc (.aclk(aclk), .aresetn(aresetn), .adc_start(adc_start), .adc_result(res),
    .adc_result_valid(res_v));
  initial forever #4 aclk = ~aclk;
  // Start spacing, start count and result capture
  always @(posedge aclk) begin
    if (adc_start === 1'b1) begin
      nst <= nst + 1;
      gap <= int'(($time - t0) / 8);
      t0  <= $time;
    end
    if (res_v === 1'b1) q.push_back(res);
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (bvalid !== 1'b1);
    bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (rvalid !== 1'b1);
    d = rdata; r = rresp; rready <= 0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #400us; n_errors++; wrap_up;
  end
  initial begin
    void'($urandom(12270));
    chan = 6'($urandom); gain = 3'($urandom);
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    rd(sacq_pkg::REG_CONFIG); chk(d, sacq_pkg::CONFIG_RST);
    rd(8'h20); chk(32'(r), 32'(sacq_pkg::RESP_SLVERR));
    // Gated single run, interval 3 at 1 MHz; counts kept in range
    wr(sacq_pkg::REG_INTERVAL, 32'h3);
    wr(sacq_pkg::REG_COUNT, 32'h3);
    wr(sacq_pkg::REG_CONFIG, {5'h0, gain, 2'h0, chan, 8'h0, sacq_pkg::TB_1MHZ, 4'h2});
    q.delete(); nst = 0;
    wr(sacq_pkg::REG_CTRL, 32'h1);
    repeat (800) @(posedge aclk);
    chk(nst, 0);
    chk({chan_o, gain_o}, {chan, gain});
    gate <= 1;
    d = 0;
    for (k = 0; k < 100 && d[0] !== 1'b1; k++) begin
      repeat (50) @(posedge aclk);
      rd(sacq_pkg::REG_STATUS);
    end
    chk(d[1:0], 2'b01);
    chk(gap, 375);
    repeat (500) @(posedge aclk);
    chk(nst, 3);
    wr(sacq_pkg::REG_RDPTR, 32'h0);
    for (k = 0; k < 3; k++) begin
      rd(sacq_pkg::REG_DATA); chk(d, {16'h0, q[k]});
    end
    // Continuous mode paced by external convert pulses; no launch while active
    wr(sacq_pkg::REG_CONFIG, 32'h9);
    q.delete(); nst = 0;
    wr(sacq_pkg::REG_CTRL, 32'h1);
    repeat (12) @(posedge aclk);
    repeat (6) begin
      conv_n <= 0; repeat (10) @(posedge aclk);
      conv_n <= 1; repeat (10) @(posedge aclk);
    end
    repeat (10) @(posedge aclk);
    chk(nst, 5);
    wr(sacq_pkg::REG_CTRL, 32'h1);
    rd(sacq_pkg::REG_CONFIG); chk(d, 32'h9);
    rd(sacq_pkg::REG_ACQCNT); chk(d, 32'h5);
    rd(sacq_pkg::REG_STATUS); chk(d[1:0], 2'b10);
    wr(sacq_pkg::REG_CTRL, 32'h2);
    rd(sacq_pkg::REG_STATUS); chk(d[1:0], 2'b00);
    wrap_up;
  end
endmodule // tb_top
